//--- core/rgm_pkg.sv
// Package of constants and types for the reset event flag controller
package rgm_pkg;
    // ========================================================================
    // Register offsets
    // ========================================================================
    localparam logic [7:0] ADDR_DES      = 8'h00;
    localparam logic [7:0] ADDR_FES      = 8'h04;
    localparam logic [7:0] ADDR_EXT_EN   = 8'h08;
    localparam logic [7:0] ADDR_SHORT    = 8'h0C;
    localparam logic [7:0] ADDR_CTRL     = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
    localparam logic [7:0] ADDR_STATUS   = 8'h1C;

    // ========================================================================
    // Field positions and reset values
    // ========================================================================
    localparam int          CTRL_BIDIR_BIT  = 0;
    localparam int          CTRL_SWRST_BIT  = 1;
    localparam int          IRQ_DES_BIT     = 0;
    localparam int          IRQ_FES_BIT     = 1;
    localparam int          IRQ_SAFEX_BIT   = 2;
    localparam logic [31:0] RST_ZERO        = 32'h0000_0000;

    // ========================================================================
    // Timing: two-cycle synchronised clear, reset sequence stage lengths
    // ========================================================================
    localparam int          CLR_SYNC_CYCLES = 2;
    localparam int          STAGE1_NS       = 320;
    localparam int          CLK_NS          = 8;
    localparam int          STAGE1_CYCLES   = (STAGE1_NS + CLK_NS - 1) / CLK_NS;
    localparam int          STAGE_REST_CYC  = 16;

    typedef enum logic [1:0] {RGM_IDLE, RGM_STAGE1, RGM_STAGE_REST} rgm_seq_t;
endpackage

//--- core/rgm_reset_event_flag_control.sv
// Reset event flag controller with external reset output and SAFE hold
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Flag clear from software takes two cycles through a sync stage.
// - A reset during the clear abandons it; the flag stays set.
// - After an abandoned clear, later clear requests still work.
// - With bidir enable set, a source with external reset and short reset gets no external reset.
// - Bidir enable zero drives external reset; deep standby exit may drop.
// - SAFE exit blocked by active cause; cleared flag wrongly allows it.
module rgm_reset_event_flag_control
    import rgm_pkg::*;
#(
    parameter int NSRC = 8                   // Reset sources per register
)(
    input  wire logic            i_core_clk,   // System clock
    input  wire logic            i_srst,       // Sync reset, active high
    input  wire logic [7:0]      i_addr,       // Register byte address
    input  wire logic [31:0]     i_wdata,      // Write data
    input  wire logic            i_wr,         // Write strobe
    input  wire logic            i_rd,         // Read strobe
    output logic      [31:0]     o_rdata,      // Read data, next cycle
    input  wire logic [NSRC-1:0] i_des_evt,    // Destructive event pulses
    input  wire logic [NSRC-1:0] i_fes_evt,    // Functional event pulses
    input  wire logic [NSRC-1:0] i_safe_cond,  // Active SAFE request causes
    input  wire logic            i_standby,    // In deepest low power mode
    input  wire logic            i_ext_rst_in, // External reset pin level
    output logic                 o_ext_rst_out,// External reset pin drive
    output logic                 o_ext_rst_oe, // External reset pin enable
    output logic                 o_safe_hold,  // SAFE mode must be kept
    output logic                 o_seq_busy,   // Reset sequence running
    output logic                 o_irq         // Level interrupt
);
    // ========================================================================
    // Pin synchroniser: three stages, change counts when 2nd and 3rd agree
    // ========================================================================
    logic [2:0] pin_sync;
    logic       pin_lvl;
    always_ff @(posedge i_core_clk)
    begin
        pin_sync <= {pin_sync[1:0], i_ext_rst_in};
        if (i_srst)
            pin_lvl <= 1'b0;
        else if (pin_sync[2] == pin_sync[1])
            pin_lvl <= pin_sync[2];
    end

    // ========================================================================
    // Registers and bus write decode
    // ========================================================================
    logic [NSRC-1:0] des_flag, fes_flag, ext_en, short_sel;
    logic [NSRC-1:0] des_clr_req, fes_clr_req, des_clr_sync, fes_clr_sync;
    logic            bidir_en, swrst_req;
    logic [2:0]      irq_stat, irq_mask;
    logic            wr_des, wr_fes;
    logic            seq_start;
    rgm_seq_t        seq;
    logic [15:0]     seq_cnt;
    logic            standby_entry, safe_prev;

    assign wr_des = i_wr && (i_addr == ADDR_DES);
    assign wr_fes = i_wr && (i_addr == ADDR_FES);

    // Configuration registers written by software
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            ext_en    <= RST_ZERO[NSRC-1:0];
            short_sel <= RST_ZERO[NSRC-1:0];
            bidir_en  <= 1'b0;
            irq_mask  <= RST_ZERO[2:0];
        end
        else if (i_wr)
        begin
            if (i_addr == ADDR_EXT_EN)
                ext_en <= i_wdata[NSRC-1:0];
            else if (i_addr == ADDR_SHORT)
                short_sel <= i_wdata[NSRC-1:0];
            else if (i_addr == ADDR_CTRL)
                bidir_en <= i_wdata[CTRL_BIDIR_BIT];
            else if (i_addr == ADDR_IRQ_MASK)
                irq_mask <= i_wdata[2:0];
        end
    end

    // Software reset request is a one-cycle pulse into the sequencer
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
            swrst_req <= 1'b0;
        else
            swrst_req <= i_wr && (i_addr == ADDR_CTRL) &&
                         i_wdata[CTRL_SWRST_BIT];
    end

    // ========================================================================
    // Two-cycle clear pipeline; a reset sequence drops it in flight
    // ========================================================================
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst || seq_start)
        begin
            des_clr_req  <= RST_ZERO[NSRC-1:0];
            fes_clr_req  <= RST_ZERO[NSRC-1:0];
            des_clr_sync <= RST_ZERO[NSRC-1:0];
            fes_clr_sync <= RST_ZERO[NSRC-1:0];
        end
        else
        begin
            des_clr_req  <= wr_des ? i_wdata[NSRC-1:0] : '0;
            fes_clr_req  <= wr_fes ? i_wdata[NSRC-1:0] : '0;
            des_clr_sync <= des_clr_req;
            fes_clr_sync <= fes_clr_req;
        end
    end

    // Sticky flags; a new event beats a clear in the same cycle.
    // Flags survive the sequence so software can see what caused it.
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            des_flag <= RST_ZERO[NSRC-1:0];
            fes_flag <= RST_ZERO[NSRC-1:0];
        end
        else
        begin
            des_flag <= (des_flag & ~des_clr_sync) | i_des_evt;
            fes_flag <= (fes_flag & ~fes_clr_sync) | i_fes_evt;
        end
    end

    // ========================================================================
    // Reset sequencer and external reset output
    // ========================================================================
    logic [NSRC-1:0] ext_want;
    logic            pin_wake;
    // Short reset on a source suppresses its external reset when bidir enable is set (silicon defect)
    assign ext_want  = (i_des_evt | i_fes_evt) & ext_en & ~short_sel;
    assign pin_wake  = i_standby && pin_lvl;
    assign seq_start = (seq == RGM_IDLE) &&
                       ((|(i_des_evt | i_fes_evt)) || swrst_req || pin_wake);

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            seq           <= RGM_IDLE;
            seq_cnt       <= 16'h0000;
            standby_entry <= 1'b0;
            o_ext_rst_out <= 1'b0;
        end
        else
        begin
            case (seq)
                RGM_IDLE:
                begin
                    if (seq_start)
                    begin
                        seq           <= RGM_STAGE1;
                        seq_cnt       <= 16'h0000;
                        standby_entry <= pin_wake;
                        // Bidir zero asserts for the whole sequence unless a deep standby exit sees the pin let go in stage one
                        o_ext_rst_out <= !bidir_en || (|ext_want);
                    end
                end
                RGM_STAGE1:
                begin
                    // Deep standby exit loses the drive if the pin lets go
                    // early; the board must hold it through this stage
                    if (standby_entry && !pin_lvl)
                        o_ext_rst_out <= 1'b0;
                    if (seq_cnt == 16'(STAGE1_CYCLES - 1))
                    begin
                        seq     <= RGM_STAGE_REST;
                        seq_cnt <= 16'h0000;
                    end
                    else
                        seq_cnt <= seq_cnt + 16'h0001;
                end
                RGM_STAGE_REST:
                begin
                    if (seq_cnt == 16'(STAGE_REST_CYC - 1))
                    begin
                        seq           <= RGM_IDLE;
                        o_ext_rst_out <= 1'b0;
                    end
                    else
                        seq_cnt <= seq_cnt + 16'h0001;
                end
                default:
                    seq <= RGM_IDLE;
            endcase
        end
    end

    // Pin enable trails the drive by one cycle, so it also drives low for one cycle after release; the board may pull it otherwise
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_ext_rst_oe <= 1'b0;
            o_seq_busy   <= 1'b0;
        end
        else
        begin
            o_ext_rst_oe <= o_ext_rst_out;
            o_seq_busy   <= (seq != RGM_IDLE) || seq_start;
        end
    end

    // ========================================================================
    // SAFE hold: defect lets a cleared flag mask a still active cause
    // ========================================================================
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            o_safe_hold <= 1'b0;
            safe_prev   <= 1'b0;
        end
        else
        begin
            o_safe_hold <= |(i_safe_cond & fes_flag);
            safe_prev   <= o_safe_hold;
        end
    end

    // ========================================================================
    // Interrupts and read back
    // ========================================================================
    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
        begin
            irq_stat <= RST_ZERO[2:0];
            o_irq    <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat &
                         ~((i_wr && i_addr == ADDR_IRQ_STAT) ?
                           i_wdata[2:0] : 3'h0)) |
                        {safe_prev && !o_safe_hold, |i_fes_evt, |i_des_evt};
            o_irq    <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_srst)
            o_rdata <= RST_ZERO;
        else if (!i_rd)
            o_rdata <= RST_ZERO;
        else if (i_addr == ADDR_DES)
            o_rdata <= 32'(des_flag);
        else if (i_addr == ADDR_FES)
            o_rdata <= 32'(fes_flag);
        else if (i_addr == ADDR_EXT_EN)
            o_rdata <= 32'(ext_en);
        else if (i_addr == ADDR_SHORT)
            o_rdata <= 32'(short_sel);
        else if (i_addr == ADDR_CTRL)
            o_rdata <= 32'(bidir_en);
        else if (i_addr == ADDR_IRQ_STAT)
            o_rdata <= 32'(irq_stat);
        else if (i_addr == ADDR_IRQ_MASK)
            o_rdata <= 32'(irq_mask);
        else if (i_addr == ADDR_STATUS)
            o_rdata <= {30'h0, o_safe_hold, o_seq_busy};
        else
            o_rdata <= RST_ZERO;
    end

    // ========================================================================
    // Checks
    // ========================================================================
    sequence s_clear_write(int b);
        wr_des && i_wdata[b] && !i_des_evt[b] && seq == RGM_IDLE &&
        !seq_start;
    endsequence

    a_clear_two_cyc: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (s_clear_write(0) ##1 (!i_des_evt[0] && !seq_start)
         ##1 !i_des_evt[0]) |=> !des_flag[0])
        else $error("des flag not cleared after two cycles");
    a_clear_not_early: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (des_flag[0] && wr_des && i_wdata[0] && !des_clr_req[0] &&
         !des_clr_sync[0]) |=> des_flag[0])
        else $error("des flag cleared too early");
    a_clear_abandon: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (seq_start && fes_flag[4] && !fes_clr_sync[4]) |=> ##1 fes_flag[4])
        else $error("flag lost when sequence started");
    a_zero_write_keep: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (wr_des && !i_wdata[3] && des_flag[3] && !des_clr_req[3]
         && !des_clr_sync[3]) |=> ##2 des_flag[3])
        else $error("zero write cleared a flag");
    a_short_no_ext: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (seq == RGM_IDLE && seq_start && bidir_en && !swrst_req &&
         !pin_wake && ((i_des_evt | i_fes_evt) & ~short_sel) == '0)
        |=> !o_ext_rst_out)
        else $error("external reset asserted for short reset source");
    a_bidir_drive: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (seq_start && !bidir_en && !pin_wake) |=> o_ext_rst_out [*2])
        else $error("external reset not driven with bidir zero");
    a_safe_hold: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        (i_safe_cond[2] && fes_flag[2]) |=> o_safe_hold)
        else $error("SAFE exit while cause active");
    a_clear_recover: assert property (@(posedge i_core_clk)
        disable iff (i_srst)
        $fell(seq_start) |-> (des_clr_req == '0 && des_clr_sync == '0))
        else $error("abandoned clear left state behind");
endmodule
`default_nettype wire

//--- verif/rgm_board_model.sv
// Board-side reset circuitry model driving the external reset pin
`timescale 1ns/1ps
`default_nettype none
// ============================================================================
// Board reset source with pull-down pin
// ============================================================================
module rgm_board_model
#(
    parameter int HOLD = 48              // Cycles the board holds the pin
)(
    input  wire logic i_core_clk,        // System clock
    input  wire logic i_go,              // Start a board reset pulse
    input  wire logic i_dev_out,         // Device pin drive value
    input  wire logic i_dev_oe,          // Device pin drive enable
    output logic      o_pin              // Resolved pin level
);
    int cnt = 0;
    // Hold beyond the first stage so the device never sees an early release
    always_ff @(posedge i_core_clk)
    begin
        if (i_go)
            cnt <= HOLD;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end
    // Pull-down: a released pin falls to 0, it never keeps the last value
    assign o_pin = (cnt > 0) | (i_dev_oe & i_dev_out);
endmodule
`default_nettype wire

//--- verif/rgm_reset_event_flag_control_bench.sv
// Self-checking bench for the reset event flag controller
`timescale 1ns/1ps
`default_nettype none
module rgm_reset_event_flag_control_bench
    import rgm_pkg::*;
;
    logic clk = 0, srst = 1, wr = 0, rd = 0, stby = 0, go = 0, pin;
    logic [7:0] addr = 8'h00, des = 8'h00, fes = 8'h00, safe = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic ext_out, ext_oe, hold, busy, irq;
    int num_errors = 0, checks = 0, cyc = 0, n, m;
    localparam int FULL = STAGE1_CYCLES + STAGE_REST_CYC;

    rgm_reset_event_flag_control i_rgm_reset_event_flag_control (
        .i_core_clk(clk), .i_srst(srst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_des_evt(des),
        .i_fes_evt(fes), .i_safe_cond(safe), .i_standby(stby),
        .i_ext_rst_in(pin), .o_ext_rst_out(ext_out), .o_ext_rst_oe(ext_oe),
        .o_safe_hold(hold), .o_seq_busy(busy), .o_irq(irq));
    rgm_board_model i_rgm_board_model (.i_core_clk(clk), .i_go(go),
        .i_dev_out(ext_out), .i_dev_oe(ext_oe), .o_pin(pin));

    // ========================================================================
    // Clock and hang guard
    // ========================================================================
    initial forever #4 clk = ~clk;
    // Tests take about 1150 cycles; a hang is ended here at 20000 cycles, far later than that
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            num_errors++;
            end_sim();
        end
    end

    // ========================================================================
    // Shared tasks
    // ========================================================================
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk) {wr, addr, wdata} <= {1'b1, a, v};
        @(posedge clk) wr <= 1'b0;
    endtask
    // Read data stands only in the cycle after the taking edge
    task automatic rreg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk) {rd, addr} <= {1'b1, a};
        @(posedge clk) rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic pulse(input logic [7:0] dv, input logic [7:0] fv);
        @(posedge clk) {des, fes} <= {dv, fv};
        @(posedge clk) {des, fes} <= 16'h0;
    endtask
    // Count drive cycles from the starting edge on, so stage one's
    // first cycle is not missed; the enable trails by one cycle
    task automatic count_out();
        n = 0;
        m = 0;
        repeat (90)
        begin
            #1 n += (ext_out === 1'b1);
            m += (ext_oe === 1'b1);
            @(posedge clk);
        end
        for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge clk) #1;
        check(busy, 0);
        check(m, n);
    endtask
    task automatic end_sim();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================================================
    // Scenarios
    // ========================================================================
    task automatic t_reset_values();
        for (int a = 0; a <= 8'h20; a += 4)
        begin
            rreg(8'(a), d);
            check(d, RST_ZERO);
        end
    endtask
    // Write zero keeps flags, write one clears only that flag
    task automatic t_clear();
        pulse(8'h28, 8'h00);
        count_out();
        wreg(ADDR_DES, 32'h0);
        rreg(ADDR_DES, d);
        check(d, 32'h28);
        wreg(ADDR_DES, 32'h08);
        repeat (2) @(posedge clk);
        rreg(ADDR_DES, d);
        check(d, 32'h20);
    endtask
    // A sequence start one cycle after the clear write abandons it
    task automatic t_abandon();
        pulse(8'h00, 8'h10);
        count_out();
        @(posedge clk) {wr, addr, wdata} <= {1'b1, ADDR_FES, 32'h10};
        @(posedge clk) {wr, des} <= {1'b0, 8'h01};
        @(posedge clk) des <= 8'h00;
        count_out();
        rreg(ADDR_FES, d);
        check(d, 32'h10);
        wreg(ADDR_FES, 32'h10);
        wreg(ADDR_DES, 32'hFF);
        rreg(ADDR_FES, d);
        check(d, 32'h0);
    endtask
    task automatic t_ext_short();
        wreg(ADDR_CTRL, 32'h1);
        wreg(ADDR_EXT_EN, 32'h3);
        wreg(ADDR_SHORT, 32'h2);
        rreg(ADDR_EXT_EN, d);
        check(d, 32'h3);
        pulse(8'h00, 8'h01);
        count_out();
        check(n, FULL);
        pulse(8'h00, 8'h02);
        count_out();
        check(n, 0);
        wreg(ADDR_CTRL, 32'h0);
        pulse(8'h10, 8'h00);
        count_out();
        check(n, FULL);
        wreg(ADDR_FES, 32'hFF);
        wreg(ADDR_DES, 32'hFF);
    endtask
    // Standby wake by a board pulse that respects the first stage length
    task automatic t_standby();
        @(posedge clk) {stby, go} <= 2'b11;
        @(posedge clk) go <= 1'b0;
        for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge clk) #1;
        stby <= 1'b0;
        count_out();
        check(n, FULL);
    endtask
    task automatic t_safe();
        wreg(ADDR_IRQ_STAT, 32'h7);
        safe <= 8'h04;
        pulse(8'h00, 8'h04);
        count_out();
        rreg(ADDR_STATUS, d);
        check(d, 32'h2);
        wreg(ADDR_IRQ_MASK, 32'h0);
        wreg(ADDR_FES, 32'h04);
        repeat (3) @(posedge clk);
        #1 check(hold, 0);
        check(irq, 0);
        rreg(ADDR_IRQ_STAT, d);
        check(d, 32'h6);
        wreg(ADDR_IRQ_MASK, 32'h4);
        repeat (2) @(posedge clk);
        #1 check(irq, 1);
        wreg(ADDR_IRQ_STAT, 32'h4);
        repeat (2) @(posedge clk);
        #1 check(irq, 0);
        pulse(8'h00, 8'h04);
        count_out();
        check(hold, 1);
        safe <= 8'h00;
        wreg(ADDR_FES, 32'h04);
        repeat (3) @(posedge clk);
        #1 check(hold, 0);
    endtask
    // Confirm the clear by reading back before the software reset
    task automatic t_swreset();
        pulse(8'h02, 8'h00);
        count_out();
        wreg(ADDR_DES, 32'h02);
        // The clear lands two cycles after the write; read after that
        @(posedge clk);
        rreg(ADDR_DES, d);
        check(d, 32'h0);
        wreg(ADDR_CTRL, 32'h2);
        count_out();
        check(n, FULL);
        rreg(ADDR_DES, d);
        check(d, 32'h0);
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        srst <= 1'b0;
        t_reset_values();
        t_clear();
        t_abandon();
        t_ext_short();
        t_standby();
        t_safe();
        t_swreset();
        end_sim();
    end
endmodule
`default_nettype wire
